// file: include/los_pkg.sv
// Constants and types for the linear output scaler
package los_pkg;
  localparam int DATA_W     = 32;
  localparam int FRAC_W     = 0;
  localparam int DIV_STEPS  = 2 * DATA_W + 2;
  localparam logic [31:0] ZERO_VAL = 32'h0000_0000;
  typedef enum {
    LOS_IDLE,
    LOS_DIVIDE,
    LOS_DONE
  } los_state_type;
endpackage

// file: include/los_div_if.sv
// Handshake bundle between the scaler and its divider
`timescale 1ns/10ps
interface los_div_if #(parameter int W = 64);
  logic         start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic         done;
  logic [W-1:0] quotient;
  modport ctrl (output start, output dividend, output divisor, input done, input quotient);
  modport unit (input start, input dividend, input divisor, output done, output quotient);
endinterface

// file: core/los_divider.sv
// Unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/10ps
module los_divider #(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Divide request and answer
  los_div_if.unit   dv
);
  logic [W-1:0]         quo_r;
  logic [W:0]           rem_r;
  logic [W-1:0]         num_r;
  logic [$clog2(W):0]   cnt_r;
  logic                 busy_r;
  logic                 done_r;
  wire  [W:0]           shifted = {rem_r[W-1:0], num_r[W-1]};
  wire  [W:0]           trial   = shifted - {1'b0, dv.divisor};
  wire                  fits    = ~trial[W];

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r  <= '0;
      quo_r  <= '0;
      rem_r  <= '0;
      num_r  <= '0;
    end else begin
      done_r <= 1'b0;
      if (dv.start && !busy_r) begin
        busy_r <= 1'b1;
        num_r  <= dv.dividend;
        rem_r  <= '0;
        quo_r  <= '0;
        cnt_r  <= ($clog2(W)+1)'(W);
      end else if (busy_r) begin
        rem_r <= fits ? trial : shifted;
        quo_r <= {quo_r[W-2:0], fits};
        num_r <= {num_r[W-2:0], 1'b0};
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign dv.done     = done_r;
  assign dv.quotient = quo_r;
endmodule // los_divider

// file: core/los_scaler.sv
// Linear output scaler: clamp, map, clamp, alarm and undefined substitution
`timescale 1ns/10ps
module los_scaler #(
  parameter int W = los_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sample tick and source channel
  input  wire logic         sample_tick,
  input  wire logic signed [W-1:0] src_value,
  input  wire logic         src_defined,
  input  wire logic         src_fault,
  input  wire logic         over_range_state,
  input  wire logic         under_range_state,
  // Configuration
  input  wire logic         out_enable,
  input  wire logic signed [W-1:0] in_lower,
  input  wire logic signed [W-1:0] in_upper,
  input  wire logic signed [W-1:0] out_lower,
  input  wire logic signed [W-1:0] out_upper,
  input  wire logic signed [W-1:0] alarm_level,
  // Result toward the transport
  output logic signed [W-1:0] out_value,
  output logic              out_valid,
  output logic              busy
);
  localparam int DW = 2 * W + 2;

  los_div_if #(.W(DW)) div_bus ();

  los_divider #(.W(DW)) u_div (
    .clk (clk),
    .rst (rst),
    .dv  (div_bus.unit)
  );

  // Controller state and its next value
  los_pkg::los_state_type state_r;
  los_pkg::los_state_type state_nxt;
  // Result and handshake registers
  logic signed [W-1:0]    out_value_r;
  logic signed [W-1:0]    out_value_nxt;
  logic                   out_valid_r;
  logic                   out_valid_nxt;
  logic                   busy_r;
  logic                   busy_nxt;
  logic                   start_r;
  logic                   start_nxt;
  // Operands held while the divider runs
  logic                   neg_r;
  logic                   neg_nxt;
  logic [DW-1:0]          dividend_r;
  logic [DW-1:0]          dividend_nxt;
  logic [DW-1:0]          divisor_r;
  logic [DW-1:0]          divisor_nxt;
  logic signed [W-1:0]    base_r;
  logic signed [W-1:0]    base_nxt;
  logic signed [W-1:0]    olo_r;
  logic signed [W-1:0]    olo_nxt;
  logic signed [W-1:0]    ohi_r;
  logic signed [W-1:0]    ohi_nxt;

  // Input clamp
  wire signed [W-1:0] clamped =
    (src_value < in_lower) ? in_lower :
    (src_value > in_upper) ? in_upper :
    src_value;

  // Wide arithmetic avoids overflow of range products
  wire signed [W+1:0] in_off   = (W+2)'(clamped) - (W+2)'(in_lower);
  wire signed [W+1:0] in_span  = (W+2)'(in_upper) - (W+2)'(in_lower);
  wire signed [W+1:0] out_span = (W+2)'(out_upper) - (W+2)'(out_lower);
  wire signed [DW-1:0] prod    = DW'(in_off) * DW'(out_span);
  wire                prod_neg = prod[DW-1];
  wire [DW-1:0]       prod_mag = prod_neg ? DW'(-prod) : DW'(prod);
  wire                span_neg = in_span[W+1];
  wire [DW-1:0]       span_mag = span_neg ? DW'(-in_span) : DW'(in_span);

  wire alarm     = src_fault | over_range_state | under_range_state;
  wire all_zero  = (in_lower == '0) && (in_upper == '0) && (out_lower == '0)
                   && (out_upper == '0) && (alarm_level == '0);
  wire undefined = !src_defined || all_zero;
  wire flat_in   = (in_span == '0);

  // Decode of one accepted tick
  // A divide lasts DW cycles; ticks meanwhile are dropped, not queued
  wire idle      = (state_r == los_pkg::LOS_IDLE);
  wire take      = sample_tick && out_enable && idle;
  wire take_zero = take && undefined;
  wire take_alm  = take && !undefined && alarm;
  wire take_flat = take && !undefined && !alarm && flat_in;
  wire take_div  = take && !undefined && !alarm && !flat_in;
  wire quick     = take_zero || take_alm || take_flat;
  wire out_ord   = (out_lower < out_upper);

  // Immediate answers skip the divider
  wire signed [W-1:0] quick_val =
    take_zero ? W'(los_pkg::ZERO_VAL) :
    take_alm  ? alarm_level :
    out_lower;

  // Output clamp on the signed quotient
  // Base is out_lower, not the smaller limit, so inverted ranges map right
  wire signed [DW-1:0] quo_s   = neg_r ? DW'(-div_bus.quotient) : div_bus.quotient;
  wire signed [DW-1:0] scaled  = DW'(base_r) + quo_s;
  wire signed [W-1:0]  limited =
    (scaled < DW'(olo_r)) ? olo_r :
    (scaled > DW'(ohi_r)) ? ohi_r :
    W'(scaled);

  // Next-state and next-output selection
  always_comb begin
    state_nxt     = state_r;
    out_value_nxt = out_value_r;
    out_valid_nxt = 1'b0;
    start_nxt     = 1'b0;
    neg_nxt       = neg_r;
    dividend_nxt  = dividend_r;
    divisor_nxt   = divisor_r;
    base_nxt      = base_r;
    olo_nxt       = olo_r;
    ohi_nxt       = ohi_r;
    case (state_r)
      los_pkg::LOS_IDLE: begin
        if (quick) begin
          out_value_nxt = quick_val;
          out_valid_nxt = 1'b1;
        end else if (take_div) begin
          neg_nxt      = prod_neg ^ span_neg;
          dividend_nxt = prod_mag;
          divisor_nxt  = span_mag;
          base_nxt     = out_lower;
          olo_nxt      = out_ord ? out_lower : out_upper;
          ohi_nxt      = out_ord ? out_upper : out_lower;
          start_nxt    = 1'b1;
          state_nxt    = los_pkg::LOS_DIVIDE;
        end
      end
      los_pkg::LOS_DIVIDE: begin
        if (div_bus.done) begin
          state_nxt = los_pkg::LOS_DONE;
        end
      end
      los_pkg::LOS_DONE: begin
        out_value_nxt = limited;
        out_valid_nxt = 1'b1;
        state_nxt     = los_pkg::LOS_IDLE;
      end
      default: state_nxt = los_pkg::LOS_IDLE;
    endcase
  end

  // Busy follows the next state so it falls with the result strobe
  assign busy_nxt = (state_nxt != los_pkg::LOS_IDLE);

  // State and busy flag
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= los_pkg::LOS_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // One-cycle strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_r <= 1'b0;
      start_r     <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
      start_r     <= start_nxt;
    end
  end

  // Result register holds until the next strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      out_value_r <= '0;
    end else begin
      out_value_r <= out_value_nxt;
    end
  end

  // Divider operands
  always_ff @(posedge clk) begin
    if (rst) begin
      neg_r      <= 1'b0;
      dividend_r <= '0;
      divisor_r  <= '0;
    end else begin
      neg_r      <= neg_nxt;
      dividend_r <= dividend_nxt;
      divisor_r  <= divisor_nxt;
    end
  end

  // Output base and clamp limits, frozen for the whole divide
  always_ff @(posedge clk) begin
    if (rst) begin
      base_r <= '0;
      olo_r  <= '0;
      ohi_r  <= '0;
    end else begin
      base_r <= base_nxt;
      olo_r  <= olo_nxt;
      ohi_r  <= ohi_nxt;
    end
  end

  // Divider request; operands stand unchanged until done
  assign div_bus.start    = start_r;
  assign div_bus.dividend = dividend_r;
  assign div_bus.divisor  = divisor_r;

  // Outputs straight from flops
  assign out_value = out_value_r;
  assign out_valid = out_valid_r;
  assign busy      = busy_r;
endmodule // los_scaler

// file: verif/los_checker.sv
// Assertions for the linear output scaler
`timescale 1ns/10ps
module los_checker #(parameter int W = 32) (
  // Control and status
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                sample_tick,
  input wire logic                src_defined,
  input wire logic                src_fault,
  input wire logic                over_range_state,
  input wire logic                under_range_state,
  input wire logic                out_enable,
  input wire logic                out_valid,
  input wire logic                busy,
  // Values
  input wire logic signed [W-1:0] src_value,
  input wire logic signed [W-1:0] in_lower,
  input wire logic signed [W-1:0] in_upper,
  input wire logic signed [W-1:0] out_lower,
  input wire logic signed [W-1:0] out_upper,
  input wire logic signed [W-1:0] alarm_level,
  input wire logic signed [W-1:0] out_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire go = sample_tick && out_enable && !busy;
  wire allz = {in_lower, in_upper, out_lower, out_upper, alarm_level} == '0;
  wire alm = src_fault || over_range_state || under_range_state;
  wire ord = out_lower <= out_upper;
  wire pre = go && src_defined && !allz;
  logic scl_r, lo_r, hi_r;
  // Marks a result that came through the divider
  always_ff @(posedge clk) begin
    if (rst || out_valid) scl_r <= 1'h0;
    else if (busy) scl_r <= 1'h1;
    if (go) lo_r <= src_value <= in_lower;
    if (go) hi_r <= src_value >= in_upper;
  end
  property p_undef; go && !src_defined |=> out_valid && out_value == '0; endproperty
  a_undef: assert property (p_undef) else $error("undefined source not zero");
  property p_zlev; go && allz |=> out_valid && out_value == '0; endproperty
  a_zlev: assert property (p_zlev) else $error("zero levels not zero");
  property p_alarm; pre && alm |=> out_valid && out_value == alarm_level; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm level missing");
  property p_flat; pre && !alm && in_lower == in_upper |=> out_valid && out_value == out_lower;
  endproperty
  a_flat: assert property (p_flat) else $error("flat range wrong");
  property p_inlo; out_valid && scl_r && lo_r |-> out_value == out_lower; endproperty
  a_inlo: assert property (p_inlo) else $error("low input not clamped");
  property p_inhi; out_valid && scl_r && hi_r |-> out_value == out_upper; endproperty
  a_inhi: assert property (p_inhi) else $error("high input not clamped");
  property p_lo; out_valid && scl_r && ord |-> out_value >= out_lower; endproperty
  a_lo: assert property (p_lo) else $error("output under lower limit");
  property p_hi; out_valid && scl_r && ord |-> out_value <= out_upper; endproperty
  a_hi: assert property (p_hi) else $error("output over upper limit");
  c_scl: cover property (out_valid && scl_r);
  c_alm: cover property (pre && alm);
  property p_busy; pre && !alm && in_lower != in_upper |=> busy && !out_valid; endproperty
  a_busy: assert property (p_busy) else $error("scaled path not busy");
  c_flat: cover property (go && in_lower == in_upper);
  c_inv: cover property (out_valid && scl_r && !ord);
endmodule // los_checker

// file: verif/los_slave.sv
// Slave stand-in holding the last written output register
`timescale 1ns/10ps
module los_slave (
  // Clock and write strobe
  input wire logic        clk,
  input wire logic        wr,
  // Register value
  input wire logic [31:0] val
);
  logic [31:0] held_r;
  int          writes = 0;
  always @(posedge clk) if (wr) begin
    held_r <= val;
    writes <= writes + 1;
  end
endmodule // los_slave

// file: verif/tb.sv
// Testbench for the linear output scaler
`timescale 1ns/10ps
module tb;
  localparam int W = los_pkg::DATA_W;
  logic clk = 1'h0, rst = 1'h1, tick = 1'h0, def = 1'h1, flt, ovr, unr, en = 1'h1, vld, bsy;
  logic signed [W-1:0] sv = '0, il = '0, iu = 32'h0000_0064, ol = '0, ou = 32'h0000_03E8;
  logic signed [W-1:0] al = 32'h0000_0005, ov;
  int mismatches = 0, n_checks = 0, n;
  initial {flt, ovr, unr} = 3'h0;
  always #50 clk = ~clk;
  los_scaler #(.W(W)) dut (.clk(clk), .rst(rst), .sample_tick(tick), .src_value(sv),
    .src_defined(def), .src_fault(flt), .over_range_state(ovr), .under_range_state(unr),
    .out_enable(en), .in_lower(il), .in_upper(iu), .out_lower(ol), .out_upper(ou),
    .alarm_level(al), .out_value(ov), .out_valid(vld), .busy(bsy));
  los_slave slv (.clk(clk), .wr(vld), .val(ov));
  task automatic chk(string nm, logic [W-1:0] seen, logic [W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One tick, then a bounded wait for the slave write
  task automatic go(logic signed [W-1:0] s, logic [W-1:0] exp);
    n = slv.writes;
    sv = s;
    tick = 1'h1;
    @(posedge clk) #1 tick = 1'h0;
    for (int i = 0; i < 4 * los_pkg::DIV_STEPS && slv.writes == n; i++) @(posedge clk) #1;
    if (slv.writes == n) begin
      chk("slave write", slv.writes, n + 1);
      test_done;
    end else begin
      chk("slave register", slv.held_r, exp);
    end
  endtask
  // Plain, inverted, truncating and negative ranges
  task automatic t_map;
    go(32'h0000_0032, 32'h0000_01F4);
    go(32'hFFFF_FFEC, 32'h0000_0000);
    go(32'h0000_012C, 32'h0000_03E8);
    ol = 32'h0000_03E8;
    ou = 32'h0000_0000;
    go(32'h0000_0014, 32'h0000_0320);
    iu = 32'h0000_0003;
    ol = 32'h0000_000A;
    go(32'h0000_0001, 32'h0000_0007);
    il = 32'hFFFF_FF9C;
    iu = 32'h0000_0064;
    ol = 32'hFFFF_FC18;
    ou = 32'h0000_03E8;
    go(32'hFFFF_FFCE, 32'hFFFF_FE0C);
    il = 32'h0000_0000;
    ol = 32'h0000_0000;
  endtask
  // Reset in mid-divide, then a clean computation
  task automatic t_reset;
    sv = 32'h0000_0032;
    tick = 1'h1;
    @(posedge clk) #1 tick = 1'h0;
    chk("busy during divide", bsy, 1'h1);
    repeat (10) @(posedge clk);
    #1 rst = 1'h1;
    @(posedge clk) #1 rst = 1'h0;
    chk("busy after reset", bsy, 1'h0);
    chk("value after reset", ov, '0);
    chk("strobe after reset", vld, 1'h0);
    go(32'h0000_0032, 32'h0000_01F4);
    chk("busy after result", bsy, 1'h0);
  endtask
  task automatic t_alarm;
    for (int k = 0; k < 3; k++) begin
      {flt, ovr, unr} = 3'h1 << k;
      go(32'h0000_0032, al);
    end
    {flt, ovr, unr} = 3'h0;
  endtask
  task automatic t_flat;
    il = 32'h0000_0007;
    iu = 32'h0000_0007;
    ol = 32'h0000_0003;
    go(32'h0000_0009, 32'h0000_0003);
  endtask
  task automatic t_undef;
    def = 1'h0;
    flt = 1'h1;
    go(32'h0000_0032, 32'h0000_0000);
    def = 1'h1;
    flt = 1'h0;
    {il, iu, ol, ou, al} = '0;
    go(32'h0000_0032, 32'h0000_0000);
  endtask
  // Disabled output must not start anything
  task automatic t_off;
    en = 1'h0;
    n = slv.writes;
    tick = 1'h1;
    @(posedge clk) #1 tick = 1'h0;
    repeat (5) @(posedge clk);
    #1 chk("ignored tick", slv.writes, n);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'h0;
    chk("reset value", ov, '0);
    t_map;
    t_reset;
    t_alarm;
    t_flat;
    t_undef;
    t_off;
    test_done;
  end
endmodule // tb
bind los_scaler los_checker #(.W(W)) u_chk (
  .clk               (clk),
  .rst               (rst),
  .sample_tick       (sample_tick),
  .src_defined       (src_defined),
  .src_fault         (src_fault),
  .over_range_state  (over_range_state),
  .under_range_state (under_range_state),
  .out_enable        (out_enable),
  .out_valid         (out_valid),
  .busy              (busy),
  .src_value         (src_value),
  .in_lower          (in_lower),
  .in_upper          (in_upper),
  .out_lower         (out_lower),
  .out_upper         (out_upper),
  .alarm_level       (alarm_level),
  .out_value         (out_value)
);
